// file: hw/rmpsc_pkg.sv
// Package for the rail margin and pin-selected state controller.
// Assumes a single 25 MHz clock and no register bus; settings arrive as ports.
package rmpsc_pkg;

    localparam int RAILS = 24;
    localparam int STATES = 8;
    localparam int DUTY_W = 16;
    localparam int PER_W = 16;
    localparam int VOLT_W = 12;

    // Clock rate and timing counts
    localparam int CLK_HZ = 25000000;
    localparam int SEL_SKEW_NS = 1000;
    localparam int CLK_NS = 40;
    // Qualification window: twice the allowed skew, rounded up
    localparam int QUAL_CYC = (2 * SEL_SKEW_NS + CLK_NS - 1) / CLK_NS;
    // PWM period limits, 1 kHz to 1 MHz, in clock cycles
    localparam int FREQ_MIN_HZ = 1000;
    localparam int FREQ_MAX_HZ = 1000000;
    localparam int PER_MAX_CYC = CLK_HZ / FREQ_MIN_HZ;
    localparam int PER_MIN_CYC = CLK_HZ / FREQ_MAX_HZ;
    // Loop update divider: one correction step per 1 ms
    localparam int LOOP_US = 1000;
    localparam int LOOP_CYC = LOOP_US * (CLK_HZ / 1000000);
    localparam logic [DUTY_W-1:0] DUTY_RST = 16'h0000;
    localparam logic [DUTY_W-1:0] DUTY_STEP = 16'h0001;

    typedef enum logic [1:0] {IDLE_HIZ, IDLE_TRIM, IDLE_FIXED, IDLE_RSVD} rmpsc_idle_t;

    // Per-rail margin configuration
    typedef struct packed {
        rmpsc_idle_t idle_mode;
        logic inc_raises;
        logic ign_faults;
        logic [PER_W-1:0] period;
        logic [DUTY_W-1:0] fixed_duty;
        logic [VOLT_W-1:0] v_high;
        logic [VOLT_W-1:0] v_low;
        logic [VOLT_W-1:0] v_nom;
    } rmpsc_mcfg_t;

    // Per-state rail map
    typedef struct packed {
        logic enabled;
        logic soft_off;
        logic [RAILS-1:0] rail_on;
    } rmpsc_state_t;

endpackage

// file: hw/rmpsc_margin_ch.sv
// One margin channel: PWM generator plus slow closed-loop duty correction.
// Assumes the loop tick is a one-cycle enable from the parent divider.
`timescale 1ns/1ps
module rmpsc_margin_ch (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic loop_tick,
    input wire logic margin_on,
    input wire logic margin_up,
    input wire rmpsc_pkg::rmpsc_mcfg_t cfg,
    input wire logic [rmpsc_pkg::VOLT_W-1:0] v_meas,
    output logic pwm_o,
    output logic pwm_oe,
    output logic [rmpsc_pkg::DUTY_W-1:0] duty
);
    logic [rmpsc_pkg::PER_W-1:0] cnt_r;
    logic [rmpsc_pkg::PER_W-1:0] per_c;
    logic [rmpsc_pkg::DUTY_W-1:0] duty_r;
    logic [rmpsc_pkg::VOLT_W-1:0] target;
    logic closed;
    logic too_low;
    logic too_high;
    logic raise;
    logic lower;

    ////////////////////////////////////////////////////////////////////////
    // period clamped
    always_comb
    begin
        per_c = cfg.period;
        if (cfg.period < rmpsc_pkg::PER_W'(rmpsc_pkg::PER_MIN_CYC))
            per_c = rmpsc_pkg::PER_W'(rmpsc_pkg::PER_MIN_CYC);
        else if (cfg.period > rmpsc_pkg::PER_W'(rmpsc_pkg::PER_MAX_CYC))
            per_c = rmpsc_pkg::PER_W'(rmpsc_pkg::PER_MAX_CYC);
    end

    // Period counter
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            cnt_r <= '0;
        else if (cnt_r >= per_c - 1'b1)
            cnt_r <= '0;
        else
            cnt_r <= cnt_r + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // target selection
    always_comb
    begin
        target = cfg.v_nom;
        if (margin_on)
            target = margin_up ? cfg.v_high : cfg.v_low;
        closed = margin_on || (cfg.idle_mode == rmpsc_pkg::IDLE_TRIM);
        too_low = v_meas < target;
        too_high = v_meas > target;
        raise = cfg.inc_raises ? too_low : too_high;
        lower = cfg.inc_raises ? too_high : too_low;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            duty_r <= rmpsc_pkg::DUTY_RST;
        else if (!closed)
            duty_r <= cfg.fixed_duty;
        else if (loop_tick && raise && duty_r < per_c)
            duty_r <= duty_r + rmpsc_pkg::DUTY_STEP;
        else if (loop_tick && lower && duty_r != '0)
            duty_r <= duty_r - rmpsc_pkg::DUTY_STEP;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            pwm_o <= 1'b0;
            pwm_oe <= 1'b0;
        end
        else
        begin
            pwm_oe <= margin_on || (cfg.idle_mode != rmpsc_pkg::IDLE_HIZ);
            pwm_o <= (margin_on || (cfg.idle_mode != rmpsc_pkg::IDLE_HIZ)) && (cnt_r < duty_r);
        end
    end

    assign duty = duty_r;
endmodule

// file: hw/rmpsc_top.sv
// Top of rail margin and pin-selected state controller.
// Assumes synchronous inputs on mclk; voltages arrive as sampled codes.
// Behaviour
// - margin from OPERATION or two pins
// - 24 independent PWM margin outputs
// - closed loop to margin target
// - correction far slower than supply loop
// - three idle modes when not margining
// - hi-z idle releases pin
// - trim idle holds nominal voltage
// - fixed idle uses programmed duty
// - PWM frequency 1 kHz to 1 MHz
// - per-rail fault ignore under pin margining
// - polarity sets correction direction
// - three pins pick eight rail states
// - first three inputs are selects
// - index binary, third input MSB
// - turn-on rails follow on sequencing
// - turn-off immediate or soft per state
// - unchanged rails get no action
// - acts only via OPERATION-controlled rails
`timescale 1ns/1ps
module rmpsc_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic op_margin_en,
    input wire logic op_margin_up,
    input wire logic pin_margin_en,
    input wire logic pin_margin_up,
    input wire logic pin_mode_sel,
    input wire rmpsc_pkg::rmpsc_mcfg_t mcfg [rmpsc_pkg::RAILS],
    input wire logic [rmpsc_pkg::VOLT_W-1:0] v_meas [rmpsc_pkg::RAILS],
    input wire logic [rmpsc_pkg::RAILS-1:0] ov_uv_raw,
    input wire logic [2:0] gpi_sel,
    input wire rmpsc_pkg::rmpsc_state_t state_cfg [rmpsc_pkg::STATES],
    input wire logic [rmpsc_pkg::RAILS-1:0] follow_op,
    output logic [rmpsc_pkg::RAILS-1:0] mar_o,
    output logic [rmpsc_pkg::RAILS-1:0] mar_oe,
    output logic [rmpsc_pkg::RAILS-1:0] ov_uv_fault,
    output logic margin_active,
    output logic [rmpsc_pkg::RAILS-1:0] op_on,
    output logic [rmpsc_pkg::RAILS-1:0] seq_on_req,
    output logic [rmpsc_pkg::RAILS-1:0] soft_off_req,
    output logic [rmpsc_pkg::RAILS-1:0] imm_off_req,
    output logic [2:0] cur_state
);
    logic [rmpsc_pkg::DUTY_W-1:0] duty_w [rmpsc_pkg::RAILS];
    logic [15:0] loop_cnt_r;
    logic loop_tick_r;
    logic m_en;
    logic m_up;
    logic [2:0] sel_r;
    logic [7:0] qual_r;
    logic [2:0] cur_r;
    logic [rmpsc_pkg::RAILS-1:0] op_r;
    logic [rmpsc_pkg::RAILS-1:0] on_r;
    logic [rmpsc_pkg::RAILS-1:0] soft_r;
    logic [rmpsc_pkg::RAILS-1:0] imm_r;
    logic [rmpsc_pkg::RAILS-1:0] flt_r;
    logic margin_r;
    logic apply;

    ////////////////////////////////////////////////////////////////////////
    // margin source
    always_comb
    begin
        m_en = pin_mode_sel ? pin_margin_en : op_margin_en;
        m_up = pin_mode_sel ? pin_margin_up : op_margin_up;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            loop_cnt_r <= '0;
            loop_tick_r <= 1'b0;
        end
        else if (loop_cnt_r == 16'(rmpsc_pkg::LOOP_CYC - 1))
        begin
            loop_cnt_r <= '0;
            loop_tick_r <= 1'b1;
        end
        else
        begin
            loop_cnt_r <= loop_cnt_r + 16'h0001;
            loop_tick_r <= 1'b0;
        end
    end

    for (genvar i = 0; i < rmpsc_pkg::RAILS; i++)
    begin : g_ch
        rmpsc_margin_ch u_ch (
            .mclk(mclk),
            .rst_n(rst_n),
            .loop_tick(loop_tick_r),
            .margin_on(m_en),
            .margin_up(m_up),
            .cfg(mcfg[i]),
            .v_meas(v_meas[i]),
            .pwm_o(mar_o[i]),
            .pwm_oe(mar_oe[i]),
            .duty(duty_w[i])
        );
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            flt_r <= '0;
            margin_r <= 1'b0;
        end
        else
        begin
            margin_r <= m_en;
            for (int i = 0; i < rmpsc_pkg::RAILS; i++)
                flt_r[i] <= ov_uv_raw[i] &&
                    !(pin_mode_sel && pin_margin_en && mcfg[i].ign_faults);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // select sampling
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            sel_r <= 3'h0;
            qual_r <= 8'h00;
        end
        else
        begin
            sel_r <= gpi_sel;
            if (gpi_sel != sel_r)
                qual_r <= 8'h00;
            else if (qual_r != 8'(rmpsc_pkg::QUAL_CYC))
                qual_r <= qual_r + 8'h01;
        end
    end

    assign apply = (qual_r == 8'(rmpsc_pkg::QUAL_CYC - 1)) && (sel_r != cur_r)
        && state_cfg[sel_r].enabled;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            cur_r <= 3'h0;
            op_r <= '0;
            on_r <= '0;
            soft_r <= '0;
            imm_r <= '0;
        end
        else
        begin
            on_r <= '0;
            soft_r <= '0;
            imm_r <= '0;
            if (apply)
            begin
                cur_r <= sel_r;
                for (int i = 0; i < rmpsc_pkg::RAILS; i++)
                begin
                    if (follow_op[i] && state_cfg[sel_r].rail_on[i] != op_r[i])
                    begin
                        op_r[i] <= state_cfg[sel_r].rail_on[i];
                        on_r[i] <= state_cfg[sel_r].rail_on[i];
                        soft_r[i] <= !state_cfg[sel_r].rail_on[i]
                            && state_cfg[sel_r].soft_off;
                        imm_r[i] <= !state_cfg[sel_r].rail_on[i]
                            && !state_cfg[sel_r].soft_off;
                    end
                end
            end
        end
    end

    assign ov_uv_fault = flt_r;
    assign margin_active = margin_r;
    assign op_on = op_r;
    assign seq_on_req = on_r;
    assign soft_off_req = soft_r;
    assign imm_off_req = imm_r;
    assign cur_state = cur_r;
endmodule

// file: tb/rmpsc_top_sva.sv
// Checker for the rail margin and pin-selected state controller.
// Assumes it is bound to rmpsc_top and sees its ports only.
`timescale 1ns/1ps
module rmpsc_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic pin_margin_en,
    input wire logic pin_mode_sel,
    input wire rmpsc_pkg::rmpsc_mcfg_t mcfg [rmpsc_pkg::RAILS],
    input wire logic [2:0] gpi_sel,
    input wire rmpsc_pkg::rmpsc_state_t state_cfg [rmpsc_pkg::STATES],
    input wire logic [rmpsc_pkg::RAILS-1:0] follow_op,
    input wire logic [rmpsc_pkg::RAILS-1:0] mar_oe,
    input wire logic [rmpsc_pkg::RAILS-1:0] ov_uv_fault,
    input wire logic margin_active,
    input wire logic [rmpsc_pkg::RAILS-1:0] op_on,
    input wire logic [rmpsc_pkg::RAILS-1:0] seq_on_req,
    input wire logic [rmpsc_pkg::RAILS-1:0] soft_off_req,
    input wire logic [rmpsc_pkg::RAILS-1:0] imm_off_req,
    input wire logic [2:0] cur_state
);
    logic [7:0] stab_r;
    logic [2:0] sel_d_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Cycles the select pins have held; saturates so long idles stay legal
    always_ff @(posedge mclk)
    begin
        sel_d_r <= gpi_sel;
        if (!rst_n || gpi_sel != sel_d_r)
            stab_r <= 8'h00;
        else if (stab_r != 8'hFF)
            stab_r <= stab_r + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////////
    state_qual_a: assert property ($changed(cur_state) |->
        stab_r >= 8'(rmpsc_pkg::QUAL_CYC - 1) && cur_state == gpi_sel)
        else $error("state applied before select settled");
    state_enabled_a: assert property ($changed(cur_state) |->
        state_cfg[cur_state].enabled) else $error("disabled state applied");
    turn_on_a: assert property ($past(rst_n) |->
        seq_on_req == (op_on & ~$past(op_on))) else $error("turn-on pulse mismatch");
    turn_off_a: assert property ($past(rst_n) |->
        (soft_off_req | imm_off_req) == ($past(op_on) & ~op_on))
        else $error("turn-off pulse mismatch");
    off_style_a: assert property (|(soft_off_req | imm_off_req) |->
        (state_cfg[cur_state].soft_off ? imm_off_req : soft_off_req) == '0)
        else $error("wrong turn-off style");
    follow_only_a: assert property ($past(rst_n) |->
        ((op_on ^ $past(op_on)) & ~follow_op) == '0) else $error("non-following rail moved");
    hiz_release_a: assert property ((!margin_active &&
        mcfg[0].idle_mode == rmpsc_pkg::IDLE_HIZ) [*3] |-> !mar_oe[0])
        else $error("tri-state idle pin driven");
    fault_mask_a: assert property ((pin_mode_sel && pin_margin_en &&
        mcfg[0].ign_faults) [*2] |-> !ov_uv_fault[0]) else $error("fault not ignored");
endmodule
bind rmpsc_top rmpsc_chk chk_u (.mclk, .rst_n, .pin_margin_en, .pin_mode_sel, .mcfg, .gpi_sel,
    .state_cfg, .follow_op, .mar_oe, .ov_uv_fault, .margin_active, .op_on, .seq_on_req,
    .soft_off_req, .imm_off_req, .cur_state);

// file: tb/rmpsc_rail_model.sv
// Behavioural R-C feedback networks for all margined rails.
// Assumes pulses arrive on mclk; a released pin puts the rail back to its fixed resting level at once.
`timescale 1ns/1ps
module rmpsc_rail_model (
    input wire logic mclk,
    input wire logic [rmpsc_pkg::RAILS-1:0] mar_o,
    input wire logic [rmpsc_pkg::RAILS-1:0] mar_oe,
    output logic [rmpsc_pkg::VOLT_W-1:0] v_meas [rmpsc_pkg::RAILS]
);
    logic [19:0] acc_r [rmpsc_pkg::RAILS];
    // Slow integrator so the rail never outruns the margin loop
    always @(posedge mclk)
    begin
        for (int i = 0; i < rmpsc_pkg::RAILS; i++)
        begin
            if (mar_oe[i] !== 1'b1)
                acc_r[i] <= 20'h10000;
            else if (mar_o[i] && acc_r[i] != 20'hFFFFF)
                acc_r[i] <= acc_r[i] + 20'h00001;
            else if (!mar_o[i] && acc_r[i] != 20'h00000)
                acc_r[i] <= acc_r[i] - 20'h00001;
        end
    end
    // Measured code is the filtered level
    always_comb
        for (int i = 0; i < rmpsc_pkg::RAILS; i++)
            v_meas[i] = acc_r[i][19:8];
endmodule

// file: tb/test_rmpsc_top.sv
// Bench for the rail margin and pin-selected state controller.
// Assumes the rail model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module test_rmpsc_top;
    logic mclk, rst_n, op_margin_en, op_margin_up, pin_margin_en, pin_margin_up;
    logic pin_mode_sel, margin_active;
    rmpsc_pkg::rmpsc_mcfg_t mcfg [rmpsc_pkg::RAILS];
    rmpsc_pkg::rmpsc_state_t state_cfg [rmpsc_pkg::STATES];
    logic [rmpsc_pkg::VOLT_W-1:0] v_meas [rmpsc_pkg::RAILS];
    logic [23:0] ov_uv_raw, follow_op, mar_o, mar_oe, ov_uv_fault, op_on, seq_on_req;
    logic [23:0] soft_off_req, imm_off_req, on_exp, got_on, got_soft, got_imm;
    logic [2:0] gpi_sel, cur_state, st_exp;
    int fails, n_compared;
    rmpsc_top dut_u (.mclk, .rst_n, .op_margin_en, .op_margin_up, .pin_margin_en, .pin_margin_up,
        .pin_mode_sel, .mcfg, .v_meas, .ov_uv_raw, .gpi_sel, .state_cfg, .follow_op, .mar_o,
        .mar_oe, .ov_uv_fault, .margin_active, .op_on, .seq_on_req, .soft_off_req,
        .imm_off_req, .cur_state);
    rmpsc_rail_model model_u (.mclk, .mar_o, .mar_oe, .v_meas);
    // Clock, 40 ns period
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // One-cycle action pulses are latched so a task can judge them later
    always @(posedge mclk)
    begin
        got_on <= got_on | seq_on_req;
        got_soft <= got_soft | soft_off_req;
        got_imm <= got_imm | imm_off_req;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic close_out();
        $display("fails=%0d n_compared=%0d", fails, n_compared);
        if (fails == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic hi_cnt(input int r, output int hi);
        hi = 0;
        repeat (250)
        begin
            tick(1);
            hi += int'(mar_o[r] === 1'b1);
        end
    endtask
    // Present a select code, then judge the outcome after the window
    task automatic go_state(input logic [2:0] sel);
        logic [23:0] prev;
        logic [2:0] st_old;
        prev = on_exp;
        st_old = st_exp;
        if (state_cfg[sel].enabled)
        begin
            st_exp = sel;
            on_exp = (state_cfg[sel].rail_on & follow_op) | (on_exp & ~follow_op);
        end
        got_on = '0;
        got_soft = '0;
        got_imm = '0;
        gpi_sel = sel;
        tick(40);
        cmp({21'h0, cur_state}, {21'h0, st_old});
        tick(40);
        cmp({21'h0, cur_state}, {21'h0, st_exp});
        cmp(op_on, on_exp);
        cmp(got_on, on_exp & ~prev);
        cmp(got_soft, state_cfg[st_exp].soft_off ? prev & ~on_exp : 24'h0);
        cmp(got_imm, state_cfg[st_exp].soft_off ? 24'h0 : prev & ~on_exp);
    endtask
    task automatic t_states();
        logic [2:0] seq [9] = '{3'h1, 3'h3, 3'h2, 3'h7, 3'h7, 3'h6, 3'h5, 3'h4, 3'h0};
        foreach (seq[i]) go_state(seq[i]);
    endtask
    task automatic t_skew();
        // short passing code, all pins move together
        gpi_sel = 3'h7;
        tick(20);
        go_state(3'h3);
    endtask
    task automatic t_idle();
        int hi;
        hi_cnt(1, hi);
        cmp(24'(hi), 24'h000064);
        hi_cnt(4, hi);
        cmp(24'(hi), 24'h000064);
        cmp({19'h0, mar_oe[4:0]}, 24'h00001E);
    endtask
    task automatic t_margin();
        int h0, h1, g0, g1;
        pin_mode_sel = 1'b1;
        mcfg[1].inc_raises = 1'b0;
        pin_margin_en = 1'b1;
        pin_margin_up = 1'b1;
        ov_uv_raw = '1;
        tick(3);
        cmp({23'h0, margin_active}, 24'h1);
        cmp({22'h0, ov_uv_fault[1:0]}, 24'h2);
        cmp({23'h0, mar_oe[0]}, 24'h1);
        hi_cnt(0, h0);
        hi_cnt(1, g0);
        tick(2 * rmpsc_pkg::LOOP_CYC);
        hi_cnt(0, h1);
        hi_cnt(1, g1);
        cmp({23'h0, h1 > h0 && h1 - h0 <= 30}, 24'h1);
        cmp({23'h0, g0 > g1 && g0 - g1 <= 30}, 24'h000001);
        pin_mode_sel = 1'b0;
        op_margin_en = 1'b1;
        tick(3);
        cmp({22'h0, ov_uv_fault[1:0]}, 24'h3);
        op_margin_en = 1'b0;
        tick(3);
        cmp({23'h0, margin_active}, 24'h0);
        pin_margin_en = 1'b0;
    endtask
    // Back in trim idle the loop keeps pulling rail 2 up toward nominal
    task automatic t_trim();
        int a, b;
        hi_cnt(2, a);
        tick(rmpsc_pkg::LOOP_CYC);
        hi_cnt(2, b);
        cmp({23'h0, b > a && b - a <= 20}, 24'h000001);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst_n, op_margin_en, op_margin_up, pin_margin_en, pin_margin_up, pin_mode_sel} = '0;
        {gpi_sel, st_exp, ov_uv_raw, on_exp, fails, n_compared} = '0;
        follow_op = 24'h7FFFFF;
        for (int i = 0; i < rmpsc_pkg::RAILS; i++)
            mcfg[i] = '{rmpsc_pkg::IDLE_TRIM, 1'b1, 1'b0, 16'h0019, 16'h000A, 12'h800,
                12'h080, 12'h400};
        mcfg[0].idle_mode = rmpsc_pkg::IDLE_HIZ;
        mcfg[0].ign_faults = 1'b1;
        mcfg[1].idle_mode = rmpsc_pkg::IDLE_FIXED;
        mcfg[4].idle_mode = rmpsc_pkg::IDLE_RSVD;
        for (int i = 0; i < rmpsc_pkg::STATES; i++)
            state_cfg[i] = '{i != 2, i % 2 == 1, {8{3'(i)}}};
        tick(6);
        rst_n = 1'b1;
        tick(2);
        cmp({21'h0, cur_state}, 24'h0);
        cmp(op_on, 24'h0);
        t_states();
        t_skew();
        t_idle();
        t_margin();
        t_trim();
        close_out();
    end
endmodule
